// [design/ccl_pkg.sv]
// constants, field layout and register map of the compare shadow/load control
// assumes a 32-bit plain register port with byte-word addressing
// Notes on behaviour
// - shadow full flags bit9 B, bit8 A
// - pair or compare-A write in shadow mode sets A flag
// - fraction-only write leaves A flag alone
// - flag self clears on load strobe
// - bit6 selects B shadow or immediate
// - bit4 selects A shadow or immediate
// - immediate mode accesses active register directly
// - bits3-2 pick B load event
// - bits1-0 pick A load event
// - load select ignored in immediate mode
// - zero at count 0, period at period
// - fraction bits15-8 hold extension, 7-0 reserved
// - compare A and fraction as 32-bit word
// - fraction follows compare-A mode and load
// - active values compared, equal events emitted
// - reset gives shadow mode, load at zero, for A and B
package ccl_pkg;

    localparam int CCL_ADDR_W = 8;
    localparam int CCL_DATA_W = 32;

    // byte addresses, one aligned word each
    localparam logic [7:0] CCL_OFS_CONTROL = 8'h00;
    localparam logic [7:0] CCL_OFS_A_PAIR = 8'h04;
    localparam logic [7:0] CCL_OFS_A_VALUE = 8'h08;
    localparam logic [7:0] CCL_OFS_A_FRACTION = 8'h0c;
    localparam logic [7:0] CCL_OFS_B_VALUE = 8'h10;

    // compare_control field positions
    localparam int CCL_B_FULL_BIT = 9;
    localparam int CCL_A_FULL_BIT = 8;
    localparam int CCL_B_MODE_BIT = 6;
    localparam int CCL_A_MODE_BIT = 4;
    localparam int CCL_B_SEL_LSB = 2;
    localparam int CCL_A_SEL_LSB = 0;

    // compare_a_fraction field position and pair layout
    localparam int CCL_FRAC_LSB = 8;
    localparam int CCL_PAIR_VALUE_LSB = 16;

    // buffer mode codes
    localparam logic CCL_MODE_SHADOW = 1'b0;
    localparam logic CCL_MODE_IMMEDIATE = 1'b1;

    // load select codes
    localparam logic [1:0] CCL_LOAD_ZERO = 2'b00;
    localparam logic [1:0] CCL_LOAD_PERIOD = 2'b01;
    localparam logic [1:0] CCL_LOAD_EITHER = 2'b10;
    localparam logic [1:0] CCL_LOAD_FREEZE = 2'b11;

    // reset values
    localparam logic [15:0] CCL_RST_VALUE = 16'h0000;
    localparam logic [7:0] CCL_RST_FRACTION = 8'h00;
    localparam logic [1:0] CCL_RST_SEL = CCL_LOAD_ZERO;
    localparam logic [15:0] CCL_COUNT_ZERO = 16'h0000;

    typedef struct packed {
        logic b_full;
        logic a_full;
        logic b_mode;
        logic a_mode;
        logic [1:0] b_sel;
        logic [1:0] a_sel;
        logic [15:0] a_shadow;
        logic [7:0] a_frac_shadow;
        logic [15:0] a_active;
        logic [7:0] a_frac_active;
        logic [15:0] b_shadow;
        logic [15:0] b_active;
        logic [31:0] rdata;
    } ccl_state_type;

endpackage : ccl_pkg

// [design/ccl_compare_shadow.sv]
// compare A/B shadow buffering, load selection, shadow full flags
// assumes timebase_count and timebase_period are synchronous to clk
`timescale 1ns/1ps
module ccl_compare_shadow
    import ccl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [CCL_ADDR_W-1:0] reg_addr,
    input wire logic [CCL_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [CCL_DATA_W-1:0] reg_rdata,
    input wire logic [15:0] timebase_count,
    input wire logic [15:0] timebase_period,
    output logic [15:0] compare_a_value,
    output logic [7:0] compare_a_fraction,
    output logic [15:0] compare_b_value,
    output logic compare_a_equal,
    output logic compare_b_equal,
    output logic a_load_strobe,
    output logic b_load_strobe
);

    ccl_state_type state;
    ccl_state_type next_state;

    logic at_zero;
    logic at_period;
    logic a_load;
    logic b_load;
    logic wr_control;
    logic wr_pair;
    logic wr_a_value;
    logic wr_a_fraction;
    logic wr_b_value;

    // the frozen code never loads, so no extra guard is needed for it
    function automatic logic ccl_load_due(
        input logic mode,
        input logic [1:0] sel,
        input logic zero_hit,
        input logic period_hit
    );
        logic due;
        due = 1'b0;
        if (mode == CCL_MODE_SHADOW)
        begin
            case (sel)
                CCL_LOAD_ZERO: due = zero_hit;
                CCL_LOAD_PERIOD: due = period_hit;
                CCL_LOAD_EITHER: due = zero_hit | period_hit;
                CCL_LOAD_FREEZE: due = 1'b0;
                default: due = 1'b0;
            endcase
        end
        return due;
    endfunction : ccl_load_due

    // the copy software sees: shadow while buffered, active while immediate
    function automatic logic [15:0] ccl_visible(
        input logic mode,
        input logic [15:0] shadow,
        input logic [15:0] active
    );
        logic [15:0] v;
        v = (mode == CCL_MODE_IMMEDIATE) ? active : shadow;
        return v;
    endfunction : ccl_visible

    assign at_zero = (timebase_count == CCL_COUNT_ZERO);
    assign at_period = (timebase_count == timebase_period);

    assign a_load = ccl_load_due(state.a_mode, state.a_sel, at_zero, at_period);
    assign b_load = ccl_load_due(state.b_mode, state.b_sel, at_zero, at_period);

    assign wr_control = reg_write && (reg_addr == CCL_OFS_CONTROL);
    assign wr_pair = reg_write && (reg_addr == CCL_OFS_A_PAIR);
    assign wr_a_value = reg_write && (reg_addr == CCL_OFS_A_VALUE);
    assign wr_a_fraction = reg_write && (reg_addr == CCL_OFS_A_FRACTION);
    assign wr_b_value = reg_write && (reg_addr == CCL_OFS_B_VALUE);

    always_comb
    begin
        logic [15:0] a_view;
        logic [7:0] frac_view;
        logic [15:0] b_view;
        logic [15:0] ctl_view;
        logic [15:0] new_a;
        logic [7:0] new_frac;
        logic a_written;
        logic frac_written;
        a_view = 16'h0000;
        frac_view = 8'h00;
        b_view = 16'h0000;
        ctl_view = 16'h0000;
        new_a = 16'h0000;
        new_frac = 8'h00;
        a_written = 1'b0;
        frac_written = 1'b0;
        next_state = state;

        // load strobes act in the very cycle the event is seen
        if (a_load)
        begin
            next_state.a_active = state.a_shadow;
            next_state.a_frac_active = state.a_frac_shadow;
            next_state.a_full = 1'b0;
        end
        if (b_load)
        begin
            next_state.b_active = state.b_shadow;
            next_state.b_full = 1'b0;
        end

        // compare A and fraction writes, alone or as one word
        if (wr_pair)
        begin
            new_a = reg_wdata[CCL_PAIR_VALUE_LSB +: 16];
            new_frac = reg_wdata[CCL_FRAC_LSB +: 8];
            a_written = 1'b1;
            frac_written = 1'b1;
        end
        else if (wr_a_value)
        begin
            new_a = reg_wdata[15:0];
            a_written = 1'b1;
        end
        else if (wr_a_fraction)
        begin
            new_frac = reg_wdata[CCL_FRAC_LSB +: 8];
            frac_written = 1'b1;
        end

        // immediate writes also update the shadow, so a later switch to
        // shadow mode does not reload a stale value
        if (a_written)
        begin
            next_state.a_shadow = new_a;
            if (state.a_mode == CCL_MODE_IMMEDIATE)
            begin
                next_state.a_active = new_a;
            end
            else
            begin
                // a write beside a load keeps the flag set: set wins
                next_state.a_full = 1'b1;
            end
        end
        if (frac_written)
        begin
            // a fraction-only write never touches a_full
            next_state.a_frac_shadow = new_frac;
            if (state.a_mode == CCL_MODE_IMMEDIATE)
            begin
                next_state.a_frac_active = new_frac;
            end
        end

        if (wr_b_value)
        begin
            next_state.b_shadow = reg_wdata[15:0];
            if (state.b_mode == CCL_MODE_IMMEDIATE)
            begin
                next_state.b_active = reg_wdata[15:0];
            end
            else
            begin
                // overwrites a waiting value if already full
                next_state.b_full = 1'b1;
            end
        end

        // full flags are read-only; reserved bits are dropped
        if (wr_control)
        begin
            next_state.b_mode = reg_wdata[CCL_B_MODE_BIT];
            next_state.a_mode = reg_wdata[CCL_A_MODE_BIT];
            next_state.b_sel = reg_wdata[CCL_B_SEL_LSB +: 2];
            next_state.a_sel = reg_wdata[CCL_A_SEL_LSB +: 2];
        end

        // read data reflect state before this cycle's update
        a_view = ccl_visible(state.a_mode, state.a_shadow, state.a_active);
        frac_view = (state.a_mode == CCL_MODE_IMMEDIATE) ?
            state.a_frac_active : state.a_frac_shadow;
        b_view = ccl_visible(state.b_mode, state.b_shadow, state.b_active);
        ctl_view[CCL_B_FULL_BIT] = state.b_full;
        ctl_view[CCL_A_FULL_BIT] = state.a_full;
        ctl_view[CCL_B_MODE_BIT] = state.b_mode;
        ctl_view[CCL_A_MODE_BIT] = state.a_mode;
        ctl_view[CCL_B_SEL_LSB +: 2] = state.b_sel;
        ctl_view[CCL_A_SEL_LSB +: 2] = state.a_sel;

        next_state.rdata = 32'h00000000;
        if (reg_read)
        begin
            case (reg_addr)
                CCL_OFS_CONTROL: next_state.rdata = {16'h0000, ctl_view};
                CCL_OFS_A_PAIR: next_state.rdata = {a_view, frac_view, 8'h00};
                CCL_OFS_A_VALUE: next_state.rdata = {16'h0000, a_view};
                CCL_OFS_A_FRACTION: next_state.rdata = {16'h0000, frac_view, 8'h00};
                CCL_OFS_B_VALUE: next_state.rdata = {16'h0000, b_view};
                default: next_state.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state.b_full <= 1'b0;
            state.a_full <= 1'b0;
            state.b_mode <= CCL_MODE_SHADOW;
            state.a_mode <= CCL_MODE_SHADOW;
            state.b_sel <= CCL_RST_SEL;
            state.a_sel <= CCL_RST_SEL;
            state.a_shadow <= CCL_RST_VALUE;
            state.a_frac_shadow <= CCL_RST_FRACTION;
            state.a_active <= CCL_RST_VALUE;
            state.a_frac_active <= CCL_RST_FRACTION;
            state.b_shadow <= CCL_RST_VALUE;
            state.b_active <= CCL_RST_VALUE;
            state.rdata <= 32'h00000000;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign compare_a_value = state.a_active;
    assign compare_a_fraction = state.a_frac_active;
    assign compare_b_value = state.b_active;

    // equality is combinational so the action logic sees it in the
    // counter's own cycle; the fraction takes no part in the match
    assign compare_a_equal = (timebase_count == state.a_active);
    assign compare_b_equal = (timebase_count == state.b_active);
    assign a_load_strobe = a_load;
    assign b_load_strobe = b_load;

endmodule : ccl_compare_shadow

// [tb/ccl_timebase_model.sv]
// time-base counter model feeding count and period to the compare block
// assumes the bench raises run only for bursts and keeps prd at 2 or more
`timescale 1ns/1ps
module ccl_timebase_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [15:0] prd,
    output logic [15:0] timebase_count,
    output logic [15:0] timebase_period
);
    assign timebase_period = prd;
    // parks at 1 when idle so no zero or period event fires between bursts
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            timebase_count <= 16'h0001;
        else if (!run)
            timebase_count <= 16'h0001;
        else if (timebase_count == prd)
            timebase_count <= 16'h0000;
        else
            timebase_count <= timebase_count + 16'h0001;
    end
endmodule : ccl_timebase_model

// [tb/ccl_compare_shadow_asserts.sv]
// port checker for the compare shadow/load block
// assumes one clk domain with rst active high, bound to every instance
`timescale 1ns/1ps
module ccl_compare_shadow_asserts
    import ccl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [CCL_ADDR_W-1:0] reg_addr,
    input wire logic [CCL_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [CCL_DATA_W-1:0] reg_rdata,
    input wire logic [15:0] timebase_count,
    input wire logic [15:0] timebase_period,
    input wire logic [15:0] compare_a_value,
    input wire logic [7:0] compare_a_fraction,
    input wire logic [15:0] compare_b_value,
    input wire logic compare_a_equal,
    input wire logic compare_b_equal,
    input wire logic a_load_strobe,
    input wire logic b_load_strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_event;
        timebase_count == CCL_COUNT_ZERO || timebase_count == timebase_period;
    endsequence
    sequence s_quiet_a; !a_load_strobe && !reg_write; endsequence
    sequence s_quiet_b; !b_load_strobe && !reg_write; endsequence
    property p_a_load; a_load_strobe |-> s_event; endproperty
    a_a_load: assert property (p_a_load) else $error("a load off event");
    property p_b_load; b_load_strobe |-> s_event; endproperty
    a_b_load: assert property (p_b_load) else $error("b load off event");
    property p_a_eq; compare_a_equal == (timebase_count == compare_a_value); endproperty
    a_a_eq: assert property (p_a_eq) else $error("a equal wrong");
    property p_b_eq; compare_b_equal == (timebase_count == compare_b_value); endproperty
    a_b_eq: assert property (p_b_eq) else $error("b equal wrong");
    property p_a_hold;
        s_quiet_a |=> $stable(compare_a_value) && $stable(compare_a_fraction);
    endproperty
    a_a_hold: assert property (p_a_hold) else $error("a moved without load");
    property p_b_hold; s_quiet_b |=> $stable(compare_b_value); endproperty
    a_b_hold: assert property (p_b_hold) else $error("b moved without load");
    property p_rd_idle; !reg_read |=> reg_rdata == 32'h00000000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_ctrl_rsv;
        reg_read && reg_addr == CCL_OFS_CONTROL |=> reg_rdata[31:10] == 22'h0
            && !reg_rdata[7] && !reg_rdata[5];
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control reserved set");
    property p_frac_rsv;
        reg_read && reg_addr == CCL_OFS_A_FRACTION |=> reg_rdata[7:0] == 8'h00;
    endproperty
    a_frac_rsv: assert property (p_frac_rsv) else $error("fraction reserved set");
endmodule : ccl_compare_shadow_asserts
bind ccl_compare_shadow ccl_compare_shadow_asserts ccl_compare_shadow_asserts_inst (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .timebase_count, .timebase_period, .compare_a_value, .compare_a_fraction,
    .compare_b_value, .compare_a_equal, .compare_b_equal, .a_load_strobe, .b_load_strobe);

// [tb/compare_shadow_load_control_tb_top.sv]
// self-checking bench for the compare shadow/load block
// assumes the time-base model is the only source of count and period
`timescale 1ns/1ps
module compare_shadow_load_control_tb_top;
    import ccl_pkg::*;
    typedef struct packed {
        logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;
    } ccl_row_type;
    ccl_row_type rows [9] = '{
        '{8'h00, 32'h0000ffff, 8'h00, 32'h0000005f},
        '{8'h00, 32'h00000000, 8'h00, 32'h00000000},
        '{8'h0c, 32'h0000ffff, 8'h00, 32'h00000000},
        '{8'h0c, 32'h0000ab12, 8'h0c, 32'h0000ab00},
        '{8'h04, 32'h12345678, 8'h00, 32'h00000100},
        '{8'h10, 32'h000000aa, 8'h00, 32'h00000300},
        '{8'h10, 32'h000000bb, 8'h10, 32'h000000bb},
        '{8'h08, 32'h00000777, 8'h04, 32'h07775600},
        '{8'h20, 32'h0000ffff, 8'h20, 32'h00000000}};
    int exp_n [4] = '{2, 2, 4, 0};
    logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, run = 1'b0;
    logic [7:0] reg_addr = 8'h00, compare_a_fraction;
    logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
    logic [15:0] prd = 16'h0008, timebase_count, timebase_period;
    logic [15:0] compare_a_value, compare_b_value;
    logic compare_a_equal, compare_b_equal, a_load_strobe, b_load_strobe;
    int failures = 0, tests_run = 0, na = 0, nb = 0;
    always #2.5 clk = ~clk;
    ccl_timebase_model ccl_timebase_model_inst (.clk, .rst, .run, .prd,
        .timebase_count, .timebase_period);
    ccl_compare_shadow ccl_compare_shadow_inst (.clk, .rst, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .timebase_count, .timebase_period,
        .compare_a_value, .compare_a_fraction, .compare_b_value, .compare_a_equal,
        .compare_b_equal, .a_load_strobe, .b_load_strobe);
    // strobes are combinational, so count them on the edge before the count moves
    always @(posedge clk)
    begin
        if (a_load_strobe === 1'b1)
            na++;
        if (b_load_strobe === 1'b1)
            nb++;
    end
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask : rd
    task automatic wait_ld(input logic b);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            if ((b ? b_load_strobe : a_load_strobe) === 1'b1)
                break;
        end
    endtask : wait_ld
    // two full periods from the idle park: two zero and two period events
    task automatic burst();
        na = 0;
        nb = 0;
        run <= 1'b1;
        repeat (18) @(posedge clk);
        run <= 1'b0;
        #1;
    endtask : burst
    initial
    begin
        #100000;
        failures++;
        tally_and_finish();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(CCL_OFS_CONTROL, 32'h00000000);
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, rows[i].ex);
        end
        chk("compare_a_value", 32'h00000000, {16'h0000, compare_a_value});
        wr(CCL_OFS_CONTROL, 32'h00000001);
        run <= 1'b1;
        wait_ld(1'b0);
        chk("a load count", {16'h0000, prd}, {16'h0000, timebase_count});
        #1 chk("compare_a_value", 32'h00000777, {16'h0000, compare_a_value});
        chk("compare_a_fraction", 32'h00000056, {24'h000000, compare_a_fraction});
        wait_ld(1'b1);
        chk("b load count", 32'h00000000, {16'h0000, timebase_count});
        run <= 1'b0;
        #1 chk("compare_b_value", 32'h000000bb, {16'h0000, compare_b_value});
        rd(CCL_OFS_CONTROL, 32'h00000001);
        for (int s = 0; s < 4; s++)
        begin
            wr(CCL_OFS_CONTROL, 32'(s * 5));
            burst();
            chk("a strobes", exp_n[s], na);
            chk("b strobes", exp_n[s], nb);
        end
        wr(CCL_OFS_CONTROL, 32'h00000050);
        wr(CCL_OFS_B_VALUE, 32'h00000003);
        #1 chk("compare_b_value", 32'h00000003, {16'h0000, compare_b_value});
        rd(CCL_OFS_B_VALUE, 32'h00000003);
        // the idle count parks at 1, so an active A of 1 matches at once
        wr(CCL_OFS_A_VALUE, 32'h00000001);
        #1 chk("compare_a_equal", 32'h00000001, {31'h00000000, compare_a_equal});
        chk("compare_b_equal", 32'h00000000, {31'h00000000, compare_b_equal});
        burst();
        chk("immediate strobes", 32'h00000000, na + nb);
        rd(CCL_OFS_CONTROL, 32'h00000050);
        // reset with the time base idle must drop the immediate values and modes
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("compare_a_value", 32'h00000000, {16'h0000, compare_a_value});
        chk("compare_b_value", 32'h00000000, {16'h0000, compare_b_value});
        rd(CCL_OFS_CONTROL, 32'h00000000);
        rd(CCL_OFS_A_VALUE, 32'h00000000);
        tally_and_finish();
    end
endmodule : compare_shadow_load_control_tb_top
